// File: input_filter.v
// Level filter: accepts a new input level after it holds steady for a count
`timescale 1ns/1ps
`default_nettype none

module input_filter #(
	parameter integer COUNT = 1200
) (
	input  wire clk_in,
	input  wire rst_b_in,
	input  wire raw_in,
	output reg  level_out
);
	reg [31:0] cnt_reg;

	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_reg   <= 32'h0000_0000;
			level_out <= 1'b0;
		end else if (raw_in == level_out) begin
			cnt_reg <= 32'h0000_0000;
		end else if (cnt_reg >= COUNT - 1) begin
			// Pulses shorter than COUNT cycles never reach here
			cnt_reg   <= 32'h0000_0000;
			level_out <= raw_in;
		end else begin
			cnt_reg <= cnt_reg + 32'h0000_0001;
		end
	end
endmodule // input_filter

`default_nettype wire

// File: io_brake_ctl.v
// Machine input conditioning, position capture and brake delay logic
// Notes on behaviour
// - Home level reported to homing sequence while home input asserted.
// - Home input edge latches reference position for homing.
// - Configured registration edge, rising or falling, latches axis position.
// - All home and registration functions disabled after reset until enabled.
// - Overtravel inputs normally closed; high means axis within limits.
// - All machine inputs except overtravel active high; overtravel inputs active low.
// - Registration inputs reject pulses shorter than 12.0 us.
// - Home function debounced by 20 ms before level change accepted.
// - Windowed capture waits at least 125 us after window opens.
// - Registration one also serves as home without extra setup.
// - Brake released while brake signal active, engaged when inactive.
// - Brake output switching delayed by engage and release delays.
// - Default mapping: input one home/capture one, input two capture two.
// - Each input assignable to any of seven function codes.
`timescale 1ns/1ps
`default_nettype none
`include "io_brake_map.vh"

module io_brake_ctl #(
	parameter integer HOME_DEBOUNCE_CYC = `HOME_DEBOUNCE_CYC,
	parameter integer WIN_DELAY_CYC     = `WIN_DELAY_CYC,
	parameter integer DELAY_UNIT_CYC    = `DELAY_UNIT_CYC
) (
	input  wire        clk_in,
	input  wire        rst_b_in,
	input  wire [31:0] haddr_in,
	input  wire [1:0]  htrans_in,
	input  wire        hwrite_in,
	input  wire [2:0]  hsize_in,
	input  wire [31:0] hwdata_in,
	input  wire        hsel_in,
	input  wire        hready_in,
	output reg  [31:0] hrdata_out,
	output wire        hreadyout_out,
	output wire        hresp_out,
	input  wire        machine_input_one_in,
	input  wire        machine_input_two_in,
	input  wire [31:0] axis_position_in,
	input  wire        capture_window_in,
	input  wire        brake_command_in,
	output wire        home_detected_out,
	output reg         brake_output_pos_out,
	output reg         brake_output_neg_out
);
	// ****************************************************************
	// Registers
	// ****************************************************************
	reg  [5:0]  input_cfg_reg;
	reg  [15:0] ctl_reg;
	reg  [4:0]  status_reg;
	reg  [31:0] cap_pos1_reg;
	reg  [31:0] cap_pos2_reg;
	reg  [31:0] home_pos_reg;
	reg  [15:0] engage_delay_reg;
	reg  [15:0] release_delay_reg;
	reg         wr_pend_reg;
	reg  [7:0]  wr_addr_reg;

	wire [1:0]  filt_reg_w;
	wire [1:0]  filt_home_w;
	wire [1:0]  raw_w;
	assign raw_w = {machine_input_two_in, machine_input_one_in};

	// ****************************************************************
	// Input filtering
	// ****************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
			input_filter #(.COUNT(`REG_FILTER_CYC)) u_reg_filt (
				.clk_in    (clk_in),
				.rst_b_in  (rst_b_in),
				.raw_in    (raw_w[gi]),
				.level_out (filt_reg_w[gi])
			);
			input_filter #(.COUNT(HOME_DEBOUNCE_CYC)) u_home_filt (
				.clk_in    (clk_in),
				.rst_b_in  (rst_b_in),
				.raw_in    (raw_w[gi]),
				.level_out (filt_home_w[gi])
			);
		end
	endgenerate

	// ****************************************************************
	// Function mapping
	// ****************************************************************
	wire [2:0] func1_w = input_cfg_reg[2:0];
	wire [2:0] func2_w = input_cfg_reg[5:3];

	// Combined mode on input one makes it both home and capture one
	wire home_src1 = (func1_w == `FUNC_HOME) || (func1_w == `FUNC_HOME_AND_CAPTURE_ONE);
	wire home_src2 = (func2_w == `FUNC_HOME) || (func2_w == `FUNC_HOME_AND_CAPTURE_ONE);
	wire reg1_src1 = (func1_w == `FUNC_REG1) || (func1_w == `FUNC_HOME_AND_CAPTURE_ONE);
	wire reg1_src2 = (func2_w == `FUNC_REG1) || (func2_w == `FUNC_HOME_AND_CAPTURE_ONE);

	wire home_lvl = (home_src1 & filt_home_w[0]) | (home_src2 & filt_home_w[1]);
	wire reg1_lvl = (reg1_src1 & filt_reg_w[0]) | (reg1_src2 & filt_reg_w[1]);
	wire reg2_lvl = ((func1_w == `FUNC_REG2) & filt_reg_w[0]) |
	                ((func2_w == `FUNC_REG2) & filt_reg_w[1]);
	// Unmapped overtravel reads as within limits
	wire pos_ok   = ((func1_w == `FUNC_POS_OT) ? filt_reg_w[0] : 1'b1) &
	                ((func2_w == `FUNC_POS_OT) ? filt_reg_w[1] : 1'b1);
	wire neg_ok   = ((func1_w == `FUNC_NEG_OT) ? filt_reg_w[0] : 1'b1) &
	                ((func2_w == `FUNC_NEG_OT) ? filt_reg_w[1] : 1'b1);

	assign home_detected_out = ctl_reg[`CTL_HOME_EN] & home_lvl;

	// ****************************************************************
	// Edge detection and window delay
	// ****************************************************************
	reg        home_d_reg;
	reg        reg1_d_reg;
	reg        reg2_d_reg;
	reg        pos_d_reg;
	reg        neg_d_reg;
	reg [31:0] win_cnt_reg;
	wire       win_ok = win_cnt_reg >= WIN_DELAY_CYC;

	wire home_edge = ctl_reg[`CTL_HOME_FALL] ? (home_d_reg & ~home_lvl) :
	                 (~home_d_reg & home_lvl);
	wire reg1_edge = ctl_reg[`CTL_REG1_FALL] ? (reg1_d_reg & ~reg1_lvl) :
	                 (~reg1_d_reg & reg1_lvl);
	wire reg2_edge = ctl_reg[`CTL_REG2_FALL] ? (reg2_d_reg & ~reg2_lvl) :
	                 (~reg2_d_reg & reg2_lvl);

	wire cap1_go = ctl_reg[`CTL_REG1_EN] & reg1_edge & ~status_reg[`ST_CAP1] &
	               (~ctl_reg[`CTL_WIN1_EN] | win_ok);
	wire cap2_go = ctl_reg[`CTL_REG2_EN] & reg2_edge & ~status_reg[`ST_CAP2] &
	               (~ctl_reg[`CTL_WIN2_EN] | win_ok);
	wire home_go = ctl_reg[`CTL_HOME_EN] & home_edge & ~status_reg[`ST_HOME_EDGE];
	wire pos_go  = ctl_reg[`CTL_OT_EN] & pos_d_reg & ~pos_ok;
	wire neg_go  = ctl_reg[`CTL_OT_EN] & neg_d_reg & ~neg_ok;

	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			home_d_reg  <= 1'b0;
			reg1_d_reg  <= 1'b0;
			reg2_d_reg  <= 1'b0;
			pos_d_reg   <= 1'b1;
			neg_d_reg   <= 1'b1;
			win_cnt_reg <= 32'h0000_0000;
		end else begin
			home_d_reg <= home_lvl;
			reg1_d_reg <= reg1_lvl;
			reg2_d_reg <= reg2_lvl;
			pos_d_reg  <= pos_ok;
			neg_d_reg  <= neg_ok;
			if (!capture_window_in)
				win_cnt_reg <= 32'h0000_0000;
			else if (!win_ok)
				win_cnt_reg <= win_cnt_reg + 32'h0000_0001;
		end
	end

	// ****************************************************************
	// Brake delay sequencer
	// ****************************************************************
	localparam [1:0] BK_ENGAGED   = 2'h0;
	localparam [1:0] BK_RELEASING = 2'h1;
	localparam [1:0] BK_RELEASED  = 2'h2;
	localparam [1:0] BK_ENGAGING  = 2'h3;

	reg  [1:0]  bk_state_reg;
	reg  [1:0]  bk_state_next;
	reg  [15:0] bk_ms_reg;
	reg  [31:0] bk_tick_reg;
	wire        bk_cmd = brake_command_in | ctl_reg[11];
	wire        tick = bk_tick_reg >= DELAY_UNIT_CYC - 1;
	wire        bk_timing = (bk_state_reg == BK_RELEASING) || (bk_state_reg == BK_ENGAGING);
	wire [15:0] bk_limit = (bk_state_reg == BK_RELEASING) ? release_delay_reg :
	                       engage_delay_reg;
	wire        bk_done = bk_ms_reg >= bk_limit;

	always @* begin
		bk_state_next = bk_state_reg;
		case (bk_state_reg)
			BK_ENGAGED:   if (bk_cmd) bk_state_next = BK_RELEASING;
			BK_RELEASING: begin
				if (!bk_cmd)
					bk_state_next = BK_ENGAGED;
				else if (bk_done)
					bk_state_next = BK_RELEASED;
			end
			BK_RELEASED:  if (!bk_cmd) bk_state_next = BK_ENGAGING;
			default: begin
				if (bk_cmd)
					bk_state_next = BK_RELEASED;
				else if (bk_done)
					bk_state_next = BK_ENGAGED;
			end
		endcase
	end

	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bk_state_reg         <= BK_ENGAGED;
			bk_ms_reg            <= 16'h0000;
			bk_tick_reg          <= 32'h0000_0000;
			brake_output_pos_out <= 1'b0;
			brake_output_neg_out <= 1'b0;
		end else begin
			bk_state_reg <= bk_state_next;
			if (!bk_timing || bk_state_next != bk_state_reg) begin
				bk_ms_reg   <= 16'h0000;
				bk_tick_reg <= 32'h0000_0000;
			end else if (tick) begin
				bk_tick_reg <= 32'h0000_0000;
				bk_ms_reg   <= bk_ms_reg + 16'h0001;
			end else begin
				bk_tick_reg <= bk_tick_reg + 32'h0000_0001;
			end
			// Coil stays powered through the engage delay
			brake_output_pos_out <= (bk_state_next == BK_RELEASED) ||
			                        (bk_state_next == BK_ENGAGING);
			brake_output_neg_out <= (bk_state_next == BK_RELEASED) ||
			                        (bk_state_next == BK_ENGAGING);
		end
	end

	// ****************************************************************
	// AHB-Lite slave
	// ****************************************************************
	wire       addr_ph = hsel_in & hready_in & htrans_in[1];
	wire [4:0] w1c = (wr_pend_reg && wr_addr_reg == `OFS_EVENT_STATUS) ?
	                 hwdata_in[4:0] : 5'h00;
	wire [4:0] set_ev = {neg_go, pos_go, home_go, cap2_go, cap1_go};
	wire       rearm_wr = wr_pend_reg && wr_addr_reg == `OFS_CAPTURE_CTL;

	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;

	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_pend_reg       <= 1'b0;
			wr_addr_reg       <= 8'h00;
			hrdata_out        <= 32'h0000_0000;
			input_cfg_reg     <= `INPUT_CFG_RST;
			ctl_reg           <= `CTL_RST;
			status_reg        <= 5'h00;
			cap_pos1_reg      <= 32'h0000_0000;
			cap_pos2_reg      <= 32'h0000_0000;
			home_pos_reg      <= 32'h0000_0000;
			engage_delay_reg  <= `DELAY_RST;
			release_delay_reg <= `DELAY_RST;
		end else begin
			wr_pend_reg <= addr_ph & hwrite_in;
			if (addr_ph)
				wr_addr_reg <= haddr_in[7:0];
			if (wr_pend_reg) begin
				if (wr_addr_reg == `OFS_INPUT_CFG)
					input_cfg_reg <= hwdata_in[5:0];
				else if (wr_addr_reg == `OFS_CAPTURE_CTL)
					ctl_reg <= {hwdata_in[15:11], 2'b00, hwdata_in[8:0]};
				else if (wr_addr_reg == `OFS_BRAKE_CTL)
					ctl_reg[11] <= hwdata_in[0];
				else if (wr_addr_reg == `OFS_ENGAGE_DELAY)
					engage_delay_reg <= hwdata_in[15:0];
				else if (wr_addr_reg == `OFS_RELEASE_DELAY)
					release_delay_reg <= hwdata_in[15:0];
			end
			// Set wins over software clear or re-arm
			status_reg <= (status_reg & ~w1c &
			               ~{3'b000, rearm_wr & hwdata_in[`CTL_REARM2],
			                 rearm_wr & hwdata_in[`CTL_REARM1]}) | set_ev;
			if (cap1_go)
				cap_pos1_reg <= axis_position_in;
			if (cap2_go)
				cap_pos2_reg <= axis_position_in;
			if (home_go)
				home_pos_reg <= axis_position_in;
			if (addr_ph && !hwrite_in) begin
				if (haddr_in[7:0] == `OFS_INPUT_CFG)
					hrdata_out <= {26'h0, input_cfg_reg};
				else if (haddr_in[7:0] == `OFS_CAPTURE_CTL)
					hrdata_out <= {16'h0, ctl_reg};
				else if (haddr_in[7:0] == `OFS_EVENT_STATUS)
					hrdata_out <= {27'h0, status_reg};
				else if (haddr_in[7:0] == `OFS_INPUT_LEVEL)
					hrdata_out <= {24'h0, bk_state_reg, home_detected_out, neg_ok,
					               pos_ok, reg2_lvl, reg1_lvl, home_lvl};
				else if (haddr_in[7:0] == `OFS_CAPTURE_POS1)
					hrdata_out <= cap_pos1_reg;
				else if (haddr_in[7:0] == `OFS_CAPTURE_POS2)
					hrdata_out <= cap_pos2_reg;
				else if (haddr_in[7:0] == `OFS_BRAKE_CTL)
					hrdata_out <= {31'h0, ctl_reg[11]};
				else if (haddr_in[7:0] == `OFS_ENGAGE_DELAY)
					hrdata_out <= {16'h0, engage_delay_reg};
				else if (haddr_in[7:0] == `OFS_RELEASE_DELAY)
					hrdata_out <= {16'h0, release_delay_reg};
				else if (haddr_in[7:0] == 8'h24)
					hrdata_out <= home_pos_reg;
				else
					hrdata_out <= 32'h0000_0000;
			end
		end
	end
endmodule // io_brake_ctl

`default_nettype wire

// File: io_brake_ctl_chk.sv
// Port assertions for the capture and brake block
`timescale 1ns/1ps
`default_nettype none
module io_brake_ctl_chk (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic machine_input_one_in,
	input wire logic brake_command_in,
	input wire logic home_detected_out,
	input wire logic brake_output_pos_out,
	input wire logic brake_output_neg_out,
	input wire logic hreadyout_out,
	input wire logic hresp_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);
	// ****************************************************************
	// Brake sequence steps
	// ****************************************************************
	sequence s_cmd_rise;
		$rose(brake_command_in) && !brake_output_pos_out;
	endsequence
	sequence s_cmd_fall;
		$fell(brake_command_in) && brake_output_pos_out;
	endsequence
	a_resp_always_okay: assert property (hresp_out == 1'b0)
		else $error("bus response not okay");
	a_ready_no_wait: assert property (hreadyout_out == 1'b1)
		else $error("bus inserted a wait");
	a_brake_pins_pair: assert property (brake_output_pos_out == brake_output_neg_out)
		else $error("brake pins differ");
	a_home_needs_input: assert property ($rose(home_detected_out) |-> $past(machine_input_one_in))
		else $error("home reported with input low");
	a_release_cause: assert property ($rose(brake_output_pos_out) |-> $past(brake_command_in))
		else $error("brake released without command");
	a_engage_cause: assert property ($fell(brake_output_pos_out) |-> !$past(brake_command_in))
		else $error("brake engaged with command high");
	a_release_delayed: assert property (s_cmd_rise |=> !brake_output_pos_out)
		else $error("brake released without delay");
	a_engage_delayed: assert property (s_cmd_fall |=> brake_output_pos_out)
		else $error("brake engaged without delay");
endmodule // io_brake_ctl_chk
bind io_brake_ctl io_brake_ctl_chk i_chk (
	.clk_in(clk_in),
	.rst_b_in(rst_b_in),
	.machine_input_one_in(machine_input_one_in),
	.brake_command_in(brake_command_in),
	.home_detected_out(home_detected_out),
	.brake_output_pos_out(brake_output_pos_out),
	.brake_output_neg_out(brake_output_neg_out),
	.hreadyout_out(hreadyout_out),
	.hresp_out(hresp_out)
);
`default_nettype wire

// File: io_brake_ctl_tb.sv
// Self-checking bench for the capture and brake block
`timescale 1ns/1ps
`default_nettype none
`include "io_brake_map.vh"
module io_brake_ctl_tb;
	logic        clk_in, rst_b_in, hwrite_in, hsel_in, in1, in2, win, bcmd;
	logic [31:0] haddr_in, hwdata_in, pos, rd_v;
	logic [1:0]  htrans_in;
	logic [2:0]  hsize_in;
	wire         hready_in, hresp_out, home_det, bpos, bneg;
	wire  [31:0] hrdata_out;
	int          err_count, cmp_count, c;
	io_brake_ctl #(.HOME_DEBOUNCE_CYC(50), .WIN_DELAY_CYC(20), .DELAY_UNIT_CYC(10)) i_dut (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
		.hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hsel_in(hsel_in),
		.hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hready_in),
		.hresp_out(hresp_out), .machine_input_one_in(in1), .machine_input_two_in(in2),
		.axis_position_in(pos), .capture_window_in(win), .brake_command_in(bcmd),
		.home_detected_out(home_det), .brake_output_pos_out(bpos), .brake_output_neg_out(bneg));
	machine_side_model i_part (.clk_in(clk_in), .in_one_out(in1), .in_two_out(in2),
		.pos_out(pos), .window_out(win), .brake_cmd_out(bcmd));
	// ****************************************************************
	// Bus and compare tasks
	// ****************************************************************
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr_in <= 32'(a);
		htrans_in <= 2'h2;
		hwrite_in <= w;
		do @(posedge clk_in); while (hready_in !== 1'b1);
		htrans_in <= 2'h0;
		hwdata_in <= d;
		do @(posedge clk_in); while (hready_in !== 1'b1);
		rd_v = hrdata_out;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
		xfer(1'b0, a, 32'h0000_0000);
		chk(n, rd_v, e);
	endtask
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// Whole run is about 30k cycles
	initial begin
		#1_000_000;
		err_count++;
		wrap_up();
	end
	initial begin
		{rst_b_in, hwrite_in, hsel_in, htrans_in} = '0;
		{haddr_in, hwdata_in} = '0;
		hsize_in = 3'h2;
		err_count = 0;
		cmp_count = 0;
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1'b1;
		hsel_in <= 1'b1;
		@(posedge clk_in);
		rchk(`OFS_INPUT_CFG, 32'h0000_001E, "cfg");
		rchk(`OFS_CAPTURE_CTL, 32'h0000_0000, "ctl");
		rchk(8'h40, 32'h0000_0000, "unmapped");
		i_part.pulse(2, 1300);
		rchk(`OFS_EVENT_STATUS, 32'h0000_0000, "disabled");
		xfer(1'b1, `OFS_CAPTURE_CTL, 32'h0000_0004);
		i_part.setv(32'h0000_1111, 1'b0);
		i_part.pulse(2, 1100);
		rchk(`OFS_EVENT_STATUS, 32'h0000_0000, "short pulse");
		i_part.pulse(2, 1300);
		rchk(`OFS_EVENT_STATUS, 32'h0000_0002, "cap2");
		rchk(`OFS_CAPTURE_POS2, 32'h0000_1112, "pos2 rise");
		i_part.pulse(2, 1300);
		rchk(`OFS_CAPTURE_POS2, 32'h0000_1112, "pos2 held");
		xfer(1'b1, `OFS_CAPTURE_CTL, 32'h0000_0424);
		rchk(`OFS_CAPTURE_CTL, 32'h0000_0024, "rearm reads");
		rchk(`OFS_EVENT_STATUS, 32'h0000_0000, "rearmed");
		i_part.setv(32'h0000_3333, 1'b0);
		i_part.pulse(2, 1300);
		rchk(`OFS_CAPTURE_POS2, 32'h0000_3334, "pos2 fall");
		xfer(1'b1, `OFS_EVENT_STATUS, 32'h0000_0002);
		rchk(`OFS_EVENT_STATUS, 32'h0000_0000, "w1c");
		xfer(1'b1, `OFS_CAPTURE_CTL, 32'h0000_0104);
		i_part.pulse(2, 1300);
		rchk(`OFS_EVENT_STATUS, 32'h0000_0000, "window shut");
		fork
			i_part.pulse(2, 1300);
			begin
				repeat (1192) @(posedge clk_in);
				i_part.setv(32'h0000_5555, 1'b1);
			end
		join
		rchk(`OFS_EVENT_STATUS, 32'h0000_0000, "window young");
		i_part.pulse(2, 1300);
		rchk(`OFS_CAPTURE_POS2, 32'h0000_5556, "window pos");
		xfer(1'b1, `OFS_EVENT_STATUS, 32'h0000_001F);
		xfer(1'b1, `OFS_CAPTURE_CTL, 32'h0000_0003);
		i_part.setv(32'h0000_6666, 1'b0);
		i_part.pulse(1, 30);
		rchk(`OFS_EVENT_STATUS, 32'h0000_0000, "home bounce");
		fork
			i_part.pulse(1, 1300);
			begin
				repeat (40) @(posedge clk_in);
				chk("home early", {31'h0, home_det}, 32'h0000_0000);
				repeat (60) @(posedge clk_in);
				chk("home seen", {31'h0, home_det}, 32'h0000_0001);
			end
		join
		rchk(`OFS_EVENT_STATUS, 32'h0000_0005, "home and cap1");
		rchk(8'h24, 32'h0000_6667, "home pos");
		rchk(`OFS_CAPTURE_POS1, 32'h0000_6667, "pos1");
		xfer(1'b1, `OFS_EVENT_STATUS, 32'h0000_001F);
		xfer(1'b1, `OFS_CAPTURE_CTL, 32'h0000_0008);
		for (c = 4; c < 6; c++) begin
			xfer(1'b1, `OFS_INPUT_CFG, 32'(c * 8 + 6));
			i_part.pulse(2, 1300);
			rchk(`OFS_EVENT_STATUS, 32'h0000_0001 << (c - 1), "overtravel");
			xfer(1'b1, `OFS_EVENT_STATUS, 32'h0000_001F);
		end
		xfer(1'b1, `OFS_ENGAGE_DELAY, 32'h0000_0002);
		xfer(1'b1, `OFS_RELEASE_DELAY, 32'h0000_0003);
		i_part.brake(1'b1);
		repeat (25) @(posedge clk_in);
		chk("release wait", {31'h0, bpos}, 32'h0000_0000);
		repeat (15) @(posedge clk_in);
		chk("released", {31'h0, bpos & bneg}, 32'h0000_0001);
		i_part.brake(1'b0);
		repeat (15) @(posedge clk_in);
		chk("engage wait", {31'h0, bpos}, 32'h0000_0001);
		repeat (15) @(posedge clk_in);
		chk("engaged", {31'h0, bpos | bneg}, 32'h0000_0000);
		wrap_up();
	end
endmodule // io_brake_ctl_tb
`default_nettype wire

// File: io_brake_map.vh
// Register map, field positions and timing counts for input capture and brake block
`ifndef IO_BRAKE_MAP_VH
`define IO_BRAKE_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_INPUT_CFG     8'h00
`define OFS_CAPTURE_CTL   8'h04
`define OFS_EVENT_STATUS  8'h08
`define OFS_INPUT_LEVEL   8'h0C
`define OFS_CAPTURE_POS1  8'h10
`define OFS_CAPTURE_POS2  8'h14
`define OFS_BRAKE_CTL     8'h18
`define OFS_ENGAGE_DELAY  8'h1C
`define OFS_RELEASE_DELAY 8'h20

// ****************************************************************
// Input function codes (3 bits per input)
// ****************************************************************
`define FUNC_NONE      3'h0
`define FUNC_HOME      3'h1
`define FUNC_REG1      3'h2
`define FUNC_REG2      3'h3
`define FUNC_POS_OT    3'h4
`define FUNC_NEG_OT    3'h5
`define FUNC_HOME_AND_CAPTURE_ONE 3'h6

// ****************************************************************
// Reset values
// ****************************************************************
`define INPUT_CFG_RST  6'h1E
`define CTL_RST        16'h0000
`define DELAY_RST      16'h0000

// ****************************************************************
// Capture control fields
// ****************************************************************
`define CTL_HOME_EN    0
`define CTL_REG1_EN    1
`define CTL_REG2_EN    2
`define CTL_OT_EN      3
`define CTL_REG1_FALL  4
`define CTL_REG2_FALL  5
`define CTL_HOME_FALL  6
`define CTL_WIN1_EN    7
`define CTL_WIN2_EN    8
`define CTL_REARM1     9
`define CTL_REARM2     10

// ****************************************************************
// Event status fields (write one to clear)
// ****************************************************************
`define ST_CAP1        0
`define ST_CAP2        1
`define ST_HOME_EDGE   2
`define ST_POS_OT      3
`define ST_NEG_OT      4

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_MHZ          100
`define REG_FILTER_NS    12000
`define REG_FILTER_CYC   ((`REG_FILTER_NS * `CLK_MHZ + 999) / 1000)
`define HOME_DEBOUNCE_MS 20
`define HOME_DEBOUNCE_CYC (`HOME_DEBOUNCE_MS * 1000 * `CLK_MHZ)
`define WIN_DELAY_US     125
`define WIN_DELAY_CYC    (`WIN_DELAY_US * `CLK_MHZ)
`define DELAY_UNIT_US    1000
`define DELAY_UNIT_CYC   (`DELAY_UNIT_US * `CLK_MHZ)

`endif

// File: machine_side_model.sv
// Machine sensors and motion controller model for the capture and brake block
`timescale 1ns/1ps
`default_nettype none
module machine_side_model (
	input  wire logic        clk_in,
	output var  logic        in_one_out,
	output var  logic        in_two_out,
	output var  logic [31:0] pos_out,
	output var  logic        window_out,
	output var  logic        brake_cmd_out
);
	initial begin
		in_one_out = 1'b0;
		in_two_out = 1'b0;
		pos_out = 32'h0000_0000;
		window_out = 1'b0;
		brake_cmd_out = 1'b0;
	end
	// ****************************************************************
	// Sensor pulse, axis moves by one count at the trailing edge
	// ****************************************************************
	task automatic pulse(input int sel, input int len);
		@(posedge clk_in);
		if (sel == 1) in_one_out <= 1'b1;
		else in_two_out <= 1'b1;
		repeat (len) @(posedge clk_in);
		if (sel == 1) in_one_out <= 1'b0;
		else in_two_out <= 1'b0;
		pos_out <= pos_out + 32'h0000_0001;
		// Settle time longer than any filter
		repeat (1300) @(posedge clk_in);
	endtask
	task automatic setv(input logic [31:0] p, input logic w);
		pos_out <= p;
		window_out <= w;
	endtask
	// Drop only after axis stop; callers space toggles far apart
	task automatic brake(input logic on);
		@(posedge clk_in);
		brake_cmd_out <= on;
	endtask
endmodule // machine_side_model
`default_nettype wire
